// file: inc/pevq_pkg.sv
// Shared constants and types of the pointer event queue
package pevq_pkg;
   // ==========================================================
   // Queue geometry
   localparam int unsigned PEVQ_DEPTH = 16;           // Events held
   localparam int unsigned PEVQ_PTR_W = 4;            // Pointer width
   localparam int unsigned PEVQ_CNT_W = 5;            // Count width, 0..16
   localparam logic [PEVQ_CNT_W-1:0] PEVQ_CNT_ZERO = 5'h00;
   localparam logic [PEVQ_CNT_W-1:0] PEVQ_CNT_ONE  = 5'h01;
   localparam logic [PEVQ_CNT_W-1:0] PEVQ_CNT_FULL = 5'h10;
   localparam logic [PEVQ_PTR_W-1:0] PEVQ_PTR_ONE  = 4'h1;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] PEVQ_OFF_IDENTITY = 8'h00;
   localparam logic [7:0] PEVQ_OFF_ADVANCE  = 8'h04;
   localparam logic [7:0] PEVQ_OFF_COUNT    = 8'h08;
   localparam logic [7:0] PEVQ_OFF_HORIZ    = 8'h0c;
   localparam logic [7:0] PEVQ_OFF_VERT     = 8'h10;
   localparam logic [7:0] PEVQ_OFF_SCROLL   = 8'h14;
   localparam logic [7:0] PEVQ_OFF_BUTTONS  = 8'h18;
   localparam logic [7:0] PEVQ_OFF_IRQ_GATE = 8'h1c;
   localparam logic [7:0] PEVQ_OFF_CAPACITY = 8'h20;
   localparam logic [7:0] PEVQ_OFF_EVT_STS  = 8'h24;
   localparam logic [7:0] PEVQ_OFF_EVT_MASK = 8'h28;

   // ==========================================================
   // Values and fields
   localparam logic [31:0] PEVQ_ADVANCE_CMD = 32'h0000_0001;
   localparam logic [31:0] PEVQ_WORD_ZERO   = 32'h0000_0000;
   localparam logic [31:0] PEVQ_ABS_MASK    = 32'h0000_7fff;
   localparam logic [31:0] PEVQ_CAP_WORD    = 32'h0000_0010;
   localparam logic        PEVQ_MODE_REL    = 1'b0;
   localparam logic        PEVQ_MODE_ABS    = 1'b1;
   localparam int unsigned PEVQ_STS_W       = 2;
   localparam int unsigned PEVQ_STS_ACCEPT  = 0;       // Event queued
   localparam int unsigned PEVQ_STS_DROP    = 1;       // Event lost, queue full
   localparam logic [PEVQ_STS_W-1:0] PEVQ_STS_NONE = 2'h0;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [7:0]  buttons;                            // Bit n = button n pressed
      logic [15:0] scroll;                             // Signed delta
      logic [15:0] horiz;                              // Delta or position
      logic [15:0] vert;                               // Delta or position
   } pevq_event_s;

   typedef struct packed {
      logic [31:0] horiz;
      logic [31:0] vert;
      logic [31:0] scroll;
      logic [31:0] buttons;
   } pevq_view_s;

   typedef struct packed {
      logic        wr;                                 // Write strobe
      logic        rd;                                 // Read strobe
      logic [7:0]  addr;                               // Byte address
      logic [31:0] wdata;                              // Write data
   } pevq_bus_s;
endpackage : pevq_pkg

// file: hw/pevq_top.sv
// Pointer event queue: event FIFO, register slave and interrupt
//
// How it works
// - Each incoming event with buttons, scroll and two coordinates is kept in a first-in first-out queue.
// - Relative mode treats coordinates as movement and absolute mode treats them as screen positions.
// - The interrupt is high while the queue holds an entry and the gate is enabled, or while a sticky event bit is set and enabled in the event mask.
// - The mode parameter gives relative behaviour at 0 and absolute at 1, with absolute as default.
// - The queue capacity is a configuration constant of sixteen events.
// - The identity register at offset zero returns one code in relative and another in absolute mode.
// - Writing one to the advance register pops the oldest event into the view registers, or does nothing if empty.
// - The count register reports waiting events and is zero after reset.
// - The horizontal register is a signed delta in relative mode and 0 to 0x7fff in absolute mode.
// - The vertical register is a signed delta in relative mode and 0 to 0x7fff in absolute mode.
// - The scroll register is always a signed delta whatever the mode.
// - The button register holds one bit per button from bit zero, set meaning pressed.
// - The gate register masks the queue interrupt at 0, enables it at 1, and resets masked.
// - The capacity register reports the configured maximum number of events.
//
// Decided for this implementation: the address-and-strobe port.
module pevq_top
   import pevq_pkg::*;
#(
   parameter logic        ABSOLUTE_MODE = PEVQ_MODE_ABS,   // 0 mouse, 1 touchscreen
   parameter logic [31:0] ID_RELATIVE   = 32'h0000_a001,   // Arbitrary value
   parameter logic [31:0] ID_ABSOLUTE   = 32'h0000_a002    // Arbitrary value
)
(
   input  wire logic        CLOCK,      // 250 MHz clock
   input  wire logic        RST_N,      // Async reset, active low
   input  wire pevq_bus_s   BUS_REQ,    // Register strobes, address, data
   output      logic [31:0] BUS_RDATA,  // Read data, cycle after strobe
   input  wire logic        EV_VALID,   // One-cycle event strobe
   input  wire pevq_event_s EV_DATA,    // Event contents
   output      logic        EV_FULL,    // Queue full, next event dropped
   output      logic        IRQ         // Level interrupt, active high
);

   // ==========================================================
   // Helpers

   // Widen a signed 16-bit field
   function automatic logic [31:0] sign_widen(input logic [15:0] v);
      sign_widen = {{16{v[15]}}, v};
   endfunction : sign_widen

   // Coordinate view for the chosen mode
   function automatic logic [31:0] coord_view(input logic [15:0] v, input logic mode);
      if (mode == PEVQ_MODE_ABS)
      begin
         coord_view = {16'h0000, v} & PEVQ_ABS_MASK;
      end
      else
      begin
         coord_view = sign_widen(v);
      end
   endfunction : coord_view

   // ==========================================================
   // State
   pevq_event_s                 mem_ff [PEVQ_DEPTH];
   logic [PEVQ_PTR_W-1:0]       wr_ptr_ff, nxt_wr_ptr;
   logic [PEVQ_PTR_W-1:0]       rd_ptr_ff, nxt_rd_ptr;
   logic [PEVQ_CNT_W-1:0]       count_ff, nxt_count;
   pevq_view_s                  view_ff, nxt_view;
   logic                        gate_ff, nxt_gate;
   logic [PEVQ_STS_W-1:0]       sts_ff, nxt_sts;
   logic [PEVQ_STS_W-1:0]       mask_ff, nxt_mask;
   logic [31:0]                 rdata_ff, nxt_rdata;
   logic                        push;
   logic                        pop;
   logic                        adv_wr;
   logic                        q_full;
   logic                        q_empty;
   pevq_event_s                 head;
   pevq_view_s                  head_view;

   // ==========================================================
   // Queue control
   // Drop on full even if a pop happens in the same cycle: keeps the
   // full decision independent of the bus, at the cost of one slot.
   always_comb
   begin
      q_full  = (count_ff == PEVQ_CNT_FULL);
      q_empty = (count_ff == PEVQ_CNT_ZERO);
      adv_wr  = BUS_REQ.wr && (BUS_REQ.addr == PEVQ_OFF_ADVANCE) && (BUS_REQ.wdata == PEVQ_ADVANCE_CMD);
      push    = EV_VALID && !q_full;
      pop     = adv_wr && !q_empty;
      head    = mem_ff[rd_ptr_ff];
      head_view.horiz   = coord_view(head.horiz, ABSOLUTE_MODE);
      head_view.vert    = coord_view(head.vert, ABSOLUTE_MODE);
      head_view.scroll  = sign_widen(head.scroll);
      head_view.buttons = {24'h000000, head.buttons};
      nxt_wr_ptr = push ? wr_ptr_ff + PEVQ_PTR_ONE : wr_ptr_ff;
      nxt_rd_ptr = pop ? rd_ptr_ff + PEVQ_PTR_ONE : rd_ptr_ff;
      nxt_count  = count_ff;
      if (push && !pop)
      begin
         nxt_count = count_ff + PEVQ_CNT_ONE;
      end
      else if (pop && !push)
      begin
         nxt_count = count_ff - PEVQ_CNT_ONE;
      end
      nxt_view = pop ? head_view : view_ff;
   end

   // Event storage, no reset needed for the payload
   always_ff @(posedge CLOCK)
   begin
      if (push)
      begin
         mem_ff[wr_ptr_ff] <= EV_DATA;
      end
   end

   // Queue pointers, count and view
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= PEVQ_CNT_ZERO;
         view_ff   <= '0;
      end
      else
      begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         count_ff  <= nxt_count;
         view_ff   <= nxt_view;
      end
   end

   // ==========================================================
   // Control registers and sticky events
   // Set wins over a same-cycle write-one-to-clear
   always_comb
   begin
      nxt_gate = gate_ff;
      nxt_mask = mask_ff;
      nxt_sts  = sts_ff;
      if (BUS_REQ.wr && (BUS_REQ.addr == PEVQ_OFF_IRQ_GATE))
      begin
         nxt_gate = BUS_REQ.wdata[0];
      end
      if (BUS_REQ.wr && (BUS_REQ.addr == PEVQ_OFF_EVT_MASK))
      begin
         nxt_mask = BUS_REQ.wdata[PEVQ_STS_W-1:0];
      end
      if (BUS_REQ.wr && (BUS_REQ.addr == PEVQ_OFF_EVT_STS))
      begin
         nxt_sts = sts_ff & ~BUS_REQ.wdata[PEVQ_STS_W-1:0];
      end
      if (push)
      begin
         nxt_sts[PEVQ_STS_ACCEPT] = 1'b1;
      end
      if (EV_VALID && q_full)
      begin
         nxt_sts[PEVQ_STS_DROP] = 1'b1;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         gate_ff <= 1'b0;
         mask_ff <= PEVQ_STS_NONE;
         sts_ff  <= PEVQ_STS_NONE;
      end
      else
      begin
         gate_ff <= nxt_gate;
         mask_ff <= nxt_mask;
         sts_ff  <= nxt_sts;
      end
   end

   // ==========================================================
   // Read path, data one cycle after the strobe
   always_comb
   begin
      nxt_rdata = PEVQ_WORD_ZERO;
      if (BUS_REQ.rd)
      begin
         case (BUS_REQ.addr)
            PEVQ_OFF_IDENTITY: nxt_rdata = (ABSOLUTE_MODE == PEVQ_MODE_ABS) ? ID_ABSOLUTE
                                                                             : ID_RELATIVE;
            PEVQ_OFF_COUNT:    nxt_rdata = {27'h0000000, count_ff};
            PEVQ_OFF_HORIZ:    nxt_rdata = view_ff.horiz;
            PEVQ_OFF_VERT:     nxt_rdata = view_ff.vert;
            PEVQ_OFF_SCROLL:   nxt_rdata = view_ff.scroll;
            PEVQ_OFF_BUTTONS:  nxt_rdata = view_ff.buttons;
            PEVQ_OFF_IRQ_GATE: nxt_rdata = {31'h00000000, gate_ff};
            PEVQ_OFF_CAPACITY: nxt_rdata = PEVQ_CAP_WORD;
            PEVQ_OFF_EVT_STS:  nxt_rdata = {30'h00000000, sts_ff};
            PEVQ_OFF_EVT_MASK: nxt_rdata = {30'h00000000, mask_ff};
            default:           nxt_rdata = PEVQ_WORD_ZERO;  // Unmapped and advance read zero
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rdata_ff <= PEVQ_WORD_ZERO;
      end
      else
      begin
         rdata_ff <= nxt_rdata;
      end
   end

   // ==========================================================
   // Outputs
   // Gate acts on the queue level, so software need clear only the sticky event bits
   assign IRQ       = (gate_ff && !q_empty) || |(sts_ff & mask_ff);
   assign EV_FULL   = q_full;
   assign BUS_RDATA = rdata_ff;

   // ==========================================================
   // Checks
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);

   property p_push_count;
      (push && !pop) |=> (count_ff == $past(count_ff) + PEVQ_CNT_ONE);
   endproperty
   a_push_count: assert property (p_push_count) else $error("count missed a push");

   property p_pop_load;
      // A same-cycle arrival keeps the count where it was
      pop |=> (view_ff == $past(head_view))
              && (count_ff == ($past(push) ? $past(count_ff) : $past(count_ff) - PEVQ_CNT_ONE));
   endproperty
   a_pop_load: assert property (p_pop_load) else $error("advance did not load head");

   property p_pop_empty;
      (adv_wr && q_empty && !EV_VALID) |=> $stable(view_ff) && (count_ff == PEVQ_CNT_ZERO);
   endproperty
   a_pop_empty: assert property (p_pop_empty) else $error("advance on empty changed state");

   property p_irq_follows;
      // Only the next cycle is promised: an advance may empty the queue right after
      (gate_ff && q_empty && push && !adv_wr) |=> IRQ && (count_ff == PEVQ_CNT_ONE);
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("interrupt not raised");

   property p_irq_masked;
      (!gate_ff && (mask_ff == PEVQ_STS_NONE)) |-> !IRQ;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("interrupt high while masked");

   property p_abs_range;
      (ABSOLUTE_MODE == PEVQ_MODE_ABS) |-> (view_ff.horiz[31:15] == '0) && (view_ff.vert[31:15] == '0);
   endproperty
   a_abs_range: assert property (p_abs_range) else $error("absolute coordinate out of range");

   property p_rel_sign;
      (ABSOLUTE_MODE == PEVQ_MODE_REL) |-> (view_ff.horiz[31:16] == {16{view_ff.horiz[15]}})
                                          && (view_ff.vert[31:16] == {16{view_ff.vert[15]}});
   endproperty
   a_rel_sign: assert property (p_rel_sign) else $error("relative delta not sign widened");

   property p_scroll_sign;
      pop |=> (view_ff.scroll[31:16] == {16{view_ff.scroll[15]}});
   endproperty
   a_scroll_sign: assert property (p_scroll_sign) else $error("scroll not signed");

   property p_drop_full;
      (EV_VALID && q_full && !pop) |=> (count_ff == PEVQ_CNT_FULL) && sts_ff[PEVQ_STS_DROP] && $stable(wr_ptr_ff);
   endproperty
   a_drop_full: assert property (p_drop_full) else $error("full queue took an event");

   property p_view_hold;
      !pop |=> $stable(view_ff);
   endproperty
   a_view_hold: assert property (p_view_hold) else $error("view changed without advance");

   property p_read_cap;
      (BUS_REQ.rd && (BUS_REQ.addr == PEVQ_OFF_CAPACITY)) |=> (BUS_RDATA == PEVQ_CAP_WORD);
   endproperty
   a_read_cap: assert property (p_read_cap) else $error("capacity read wrong");

   property p_read_count;
      (BUS_REQ.rd && (BUS_REQ.addr == PEVQ_OFF_COUNT)) |=> (BUS_RDATA[4:0] == $past(count_ff));
   endproperty
   a_read_count: assert property (p_read_count) else $error("count read wrong");

   property p_read_id;
      (BUS_REQ.rd && (BUS_REQ.addr == PEVQ_OFF_IDENTITY))
         |=> (BUS_RDATA == ((ABSOLUTE_MODE == PEVQ_MODE_ABS) ? ID_ABSOLUTE : ID_RELATIVE));
   endproperty
   a_read_id: assert property (p_read_id) else $error("identity read wrong");

   property p_read_buttons;
      (BUS_REQ.rd && (BUS_REQ.addr == PEVQ_OFF_BUTTONS)) |=> (BUS_RDATA[31:8] == '0);
   endproperty
   a_read_buttons: assert property (p_read_buttons) else $error("button read wrong");

endmodule : pevq_top

// file: dv/pevq_ptr_model.sv
// Pointing device model that feeds events to the queue
module pevq_ptr_model
   import pevq_pkg::*;
(
   input  wire logic        CLOCK,     // Bench clock
   output      logic        EV_VALID,  // Event strobe
   output      pevq_event_s EV_DATA    // Event payload
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Idle state at time zero
   initial
   begin
      EV_VALID = 1'b0;
      EV_DATA  = '0;
   end

   // ==========================================================
   // One strobe per event, back to back, oldest first
   // Payload inverted after the burst, so a stale value never looks valid
   task automatic send_seq(input pevq_event_s evs[$]);
      foreach (evs[k])
      begin
         @(posedge CLOCK);
         EV_VALID <= 1'b1;
         EV_DATA  <= evs[k];
      end
      @(posedge CLOCK);
      EV_VALID <= 1'b0;
      EV_DATA  <= ~EV_DATA;
   endtask : send_seq
endmodule : pevq_ptr_model

// file: dv/tb_top.sv
// Self-checking bench for the pointer event queue, both coordinate modes
module tb_top
   import pevq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [31:0] ID_REL_T = 32'h0000_5a01;  // Arbitrary value
   localparam logic [31:0] ID_ABS_T = 32'h0000_5a02;  // Arbitrary value

   logic        clock;
   logic        rst_n;
   pevq_bus_s   bus_req;
   logic [31:0] rdata_abs, rdata_rel;
   logic        ev_valid, full_abs, full_rel, irq_abs, irq_rel;
   pevq_event_s ev_data;
   int          n_mismatch, n_checks;

   // ==========================================================
   // Clock, two instances and the device model
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // Mode left at its default here, so the default is exercised
   pevq_top #(.ID_RELATIVE(ID_REL_T), .ID_ABSOLUTE(ID_ABS_T)) pevq_top_i (.CLOCK(clock), .RST_N(rst_n),
      .BUS_REQ(bus_req), .BUS_RDATA(rdata_abs), .EV_VALID(ev_valid), .EV_DATA(ev_data),
      .EV_FULL(full_abs), .IRQ(irq_abs));
   pevq_top #(.ABSOLUTE_MODE(PEVQ_MODE_REL), .ID_RELATIVE(ID_REL_T), .ID_ABSOLUTE(ID_ABS_T)) pevq_top_rel_i (
      .CLOCK(clock), .RST_N(rst_n), .BUS_REQ(bus_req), .BUS_RDATA(rdata_rel), .EV_VALID(ev_valid),
      .EV_DATA(ev_data), .EV_FULL(full_rel), .IRQ(irq_rel));
   pevq_ptr_model pevq_ptr_model_i (.CLOCK(clock), .EV_VALID(ev_valid), .EV_DATA(ev_data));

   // ==========================================================
   // Compare, bus and expectation helpers
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clock);
      bus_req <= '0;
      #1;
   endtask : bus_wr

   // Read data stand only in the cycle after the strobe
   task automatic rd_both(input logic [7:0] a, input string what, input logic [31:0] ea, input logic [31:0] er);
      @(posedge clock);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(posedge clock);
      bus_req <= '0;
      #1;
      check({what, " abs"}, rdata_abs, ea);
      check({what, " rel"}, rdata_rel, er);
   endtask : rd_both

   function automatic pevq_view_s exp_view(input pevq_event_s e, input logic absm);
      pevq_view_s v;
      v.horiz   = absm ? {17'h0, e.horiz[14:0]} : {{16{e.horiz[15]}}, e.horiz};
      v.vert    = absm ? {17'h0, e.vert[14:0]} : {{16{e.vert[15]}}, e.vert};
      v.scroll  = {{16{e.scroll[15]}}, e.scroll};
      v.buttons = {24'h0, e.buttons};
      return v;
   endfunction : exp_view

   task automatic check_view(input pevq_event_s e);
      pevq_view_s va, vr;
      va = exp_view(e, 1'b1);
      vr = exp_view(e, 1'b0);
      rd_both(PEVQ_OFF_HORIZ, "horiz", va.horiz, vr.horiz);
      rd_both(PEVQ_OFF_VERT, "vert", va.vert, vr.vert);
      rd_both(PEVQ_OFF_SCROLL, "scroll", va.scroll, vr.scroll);
      rd_both(PEVQ_OFF_BUTTONS, "buttons", va.buttons, vr.buttons);
   endtask : check_view

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   // ==========================================================
   // Watchdog, so a hang still reaches the report
   initial
   begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      $display("[FAIL] run length expected finish seen hang");
      tally_and_finish();
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      pevq_event_s evs[$];
      pevq_event_s expq[$];
      pevq_event_s ev;
      logic [7:0]  zoffs[9];
      rst_n      = 1'b0;
      bus_req    = '0;
      n_mismatch = 0;
      n_checks   = 0;
      zoffs      = '{PEVQ_OFF_COUNT, PEVQ_OFF_HORIZ, PEVQ_OFF_VERT, PEVQ_OFF_SCROLL, PEVQ_OFF_BUTTONS,
                     PEVQ_OFF_IRQ_GATE, PEVQ_OFF_EVT_STS, PEVQ_OFF_EVT_MASK, 8'h2c};
      void'($urandom(21294));
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      // Reset values, identity per mode, capacity, unmapped place
      foreach (zoffs[k]) rd_both(zoffs[k], "reset value", 32'h0, 32'h0);
      rd_both(PEVQ_OFF_IDENTITY, "identity", ID_ABS_T, ID_REL_T);
      rd_both(PEVQ_OFF_CAPACITY, "capacity", 32'h10, 32'h10);
      // Advance on empty queue changes nothing
      bus_wr(PEVQ_OFF_ADVANCE, 32'h1);
      rd_both(PEVQ_OFF_COUNT, "count empty", 32'h0, 32'h0);
      check_view('0);
      // Seventeen events back to back, corner values first; last is dropped
      for (int i = 0; i < 17; i++)
      begin
         ev = pevq_event_s'(56'({$urandom, $urandom}));
         if (i == 0) ev.horiz = 16'h8000;
         if (i == 1) ev = '{buttons: 8'h81, scroll: 16'h8001, horiz: 16'hffff, vert: 16'h7fff};
         evs.push_back(ev);
         if (expq.size() < 16) expq.push_back(ev);
      end
      pevq_ptr_model_i.send_seq(evs);
      #1;
      check("irq masked", {31'h0, irq_abs}, 32'h0);
      check("full", {30'h0, full_abs, full_rel}, 32'h3);
      rd_both(PEVQ_OFF_COUNT, "count full", 32'h10, 32'h10);
      rd_both(PEVQ_OFF_EVT_STS, "status", 32'h3, 32'h3);
      // Drop status through its mask, then cleared by writing one
      bus_wr(PEVQ_OFF_EVT_MASK, 32'h2);
      check("irq drop", {31'h0, irq_abs}, 32'h1);
      bus_wr(PEVQ_OFF_EVT_STS, 32'h2);
      check("irq drop clear", {31'h0, irq_abs}, 32'h0);
      bus_wr(PEVQ_OFF_EVT_MASK, 32'h0);
      bus_wr(PEVQ_OFF_IRQ_GATE, 32'h1);
      check("irq gated", {30'h0, irq_abs, irq_rel}, 32'h3);
      rd_both(PEVQ_OFF_IRQ_GATE, "gate", 32'h1, 32'h1);
      // Advance with a value other than one is ignored
      bus_wr(PEVQ_OFF_ADVANCE, 32'h2);
      rd_both(PEVQ_OFF_COUNT, "count bad advance", 32'h10, 32'h10);
      // First pop, then a late arrival must not disturb the view
      ev = expq.pop_front();
      bus_wr(PEVQ_OFF_ADVANCE, 32'h1);
      check_view(ev);
      evs = '{pevq_event_s'(56'({$urandom, $urandom}))};
      expq.push_back(evs[0]);
      pevq_ptr_model_i.send_seq(evs);
      check_view(ev);
      // Drain in arrival order
      while (expq.size() > 0)
      begin
         rd_both(PEVQ_OFF_COUNT, "count", 32'(expq.size()), 32'(expq.size()));
         ev = expq.pop_front();
         bus_wr(PEVQ_OFF_ADVANCE, 32'h1);
         check_view(ev);
      end
      check("irq empty", {29'h0, irq_abs, irq_rel, full_abs}, 32'h0);
      bus_wr(PEVQ_OFF_ADVANCE, 32'h1);
      check_view(ev);
      // One event into the empty gated queue raises the line, gate off drops it
      evs = '{pevq_event_s'(56'({$urandom, $urandom}))};
      pevq_ptr_model_i.send_seq(evs);
      #1;
      check("irq one entry", {30'h0, irq_abs, irq_rel}, 32'h3);
      bus_wr(PEVQ_OFF_IRQ_GATE, 32'h0);
      check("irq gate off", {30'h0, irq_abs, irq_rel}, 32'h0);
      bus_wr(PEVQ_OFF_ADVANCE, 32'h1);
      check_view(evs[0]);
      tally_and_finish();
   end
endmodule : tb_top
